/* adc_ctrl.sv */
// Sequencer, register file and threshold compare of a 12-channel 10-bit converter.
// Assumes the mode register lives outside and feeds enable, trigger and scan levels,
// that the external pin edge arrives already detected as a pulse, and that the
// analog front end holds a valid code on ANA_CODE when the conversion time ends.
//
// Notes on behaviour
// - Conversion lasts (code+1)*31 clocks for time code 0 to 15.
// - After enable rises, wait 16, 31, 47 or 50 clocks before converting.
// - Reset clears time, trigger, channel and compare control registers.
// - Control registers take whole-byte writes and single-bit writes.
// - Trigger select picks external edge, timer event 0, or timer event 1.
// - Channel code sits in bits 3..0, upper bits zero; select or scan end.
// - Results are read-only; word view for 16-bit, high view for 8-bit reads.
// - Word view holds the result in bits 15..6, lower six bits zero.
// - High view returns the upper eight result bits.
// - Stored word equals the rounded approximation code times 64.
// - Compare enable is bit 7; bits 5..0 of compare control read zero.
// - Direction 0 fires on high byte at or above threshold, 1 below it.
// - Select mode with compare stores and interrupts only on a hit.
// - Scan mode with compare tests channel 0 only, storing it on a hit.
// - Compare scan keeps storing other channels; no interrupt at sweep end.
// - Trigger mode 0 starts on enable, 1 waits for the hardware trigger.
// - Timer triggers start on the rising edge of the selected event.
// - Scan converts 0 up to the code, interrupts at the end for codes 0 to 11, then restarts in trigger mode 0 or waits for the next trigger in mode 1.
// - Without compare, each conversion on channels 0 to 11 stores its result; the interrupt comes only with the last channel's store.

`timescale 1ns/100ps

module adc_ctrl
	import adc_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RSTN,
	input  wire logic [31:0] ADDR,
	input  wire logic        WR_EN,
	input  wire logic        RD_EN,
	input  wire logic        SIZE16,
	input  wire logic        BIT_OP,
	input  wire logic [2:0]  BIT_POS,
	input  wire logic [7:0]  WDATA,
	output logic      [15:0] RDATA,
	output logic             RD_VALID,
	input  wire logic        CONV_EN,
	input  wire logic        TRIG_MODE,
	input  wire logic        SCAN_MODE,
	input  wire logic [7:0]  THRESHOLD,
	input  wire logic        EXT_EDGE,
	input  wire logic        TMR_MATCH0,
	input  wire logic        TMR_MATCH1,
	input  wire logic [9:0]  ANA_CODE,
	output logic             ANA_START,
	output logic      [3:0]  ANA_CHAN,
	output logic             IRQ,
	output logic             BUSY
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		fsm_t                          fsm;
		logic [7:0]                    conv_time;
		logic [7:0]                    trig_sel;
		logic [7:0]                    chan_sel;
		logic [7:0]                    cmp_ctrl;
		logic [NUM_CH-1:0][RES_W-1:0]  res;
		logic [3:0]                    cur_ch;
		logic                          en;
		logic                          tm0;
		logic                          tm1;
		logic                          irq;
		logic [15:0]                   rdata;
		logic                          rd_valid;
		logic                          ana_start;
		logic                          busy;
	} ctrl_state_t;

	ctrl_state_t q;
	ctrl_state_t s;

	cycle_timer_if tif ();

	cycle_timer u_timer (
		.clk   (CLK),
		.rst_n (RSTN),
		.tif   (tif)
	);

	// Byte or single-bit update of a control register.
	function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [7:0] mask);
		logic [7:0] v;
		v = old;
		if (BIT_OP) begin
			v[BIT_POS] = WDATA[0];
		end else begin
			v = WDATA;
		end
		return v & mask;
	endfunction : wr_byte

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	logic       t_load;
	logic [8:0] t_count;
	logic       go;
	logic [3:0] go_ch;
	logic       trig_hit;
	logic       cfg_wr;
	logic       last_ch;
	logic       hit;
	logic [3:0] first_ch;
	logic [8:0] conv_cyc;
	logic [8:0] stab_cyc;
	logic [3:0] widx;
	logic [3:0] hidx;

	always_comb begin
		s = q;
		s.irq = 1'b0;
		s.rd_valid = 1'b0;
		s.ana_start = 1'b0;
		s.en = CONV_EN;
		s.tm0 = TMR_MATCH0;
		s.tm1 = TMR_MATCH1;
		t_load = 1'b0;
		t_count = 9'h000;
		go = 1'b0;
		cfg_wr = 1'b0;
		widx = ADDR[4:1];
		hidx = ADDR[3:0];
		first_ch = SCAN_MODE ? 4'h0 : q.chan_sel[3:0];
		last_ch = !SCAN_MODE || (q.cur_ch == q.chan_sel[3:0]);
		go_ch = first_ch;
		// The timer's expiry pulse is registered and costs one cycle, so the load is one
		// less than the conversion length; the end then falls exactly N cycles after start.
		conv_cyc = 9'(({5'h00, q.conv_time[3:0]} + 9'h001) * CONV_UNIT_CYC - 9'h001);

		// Stabilisation wait picked from the time code.
		case (q.conv_time[3:0])
			4'h0:    stab_cyc = STAB_CODE0_CYC;
			4'h1:    stab_cyc = STAB_CODE1_CYC;
			4'h2:    stab_cyc = STAB_CODE2_CYC;
			default: stab_cyc = STAB_OTHER_CYC;
		endcase

		// Hardware start source; timer events count only on their rising edge.
		case (q.trig_sel[1:0])
			TRIG_EXT_PIN: trig_hit = EXT_EDGE;
			TRIG_TIMER0:  trig_hit = TMR_MATCH0 && !q.tm0;
			TRIG_TIMER1:  trig_hit = TMR_MATCH1 && !q.tm1;
			default:      trig_hit = 1'b0;
		endcase

		// Compare of the fresh high byte against the threshold.
		if (q.cmp_ctrl[CMP_DIR_BIT]) begin
			hit = ANA_CODE[RES_W-1:2] < THRESHOLD;
		end else begin
			hit = ANA_CODE[RES_W-1:2] >= THRESHOLD;
		end

		// Register writes. Unmapped and result addresses ignore writes.
		if (WR_EN) begin
			if (ADDR == ADDR_CONV_TIME) begin
				s.conv_time = wr_byte(q.conv_time, CT_WRITE_MASK);
			end else if (ADDR == ADDR_CHAN_SEL) begin
				s.chan_sel = wr_byte(q.chan_sel, CHAN_WRITE_MASK);
				cfg_wr = 1'b1;
			end else if (ADDR == ADDR_TRIG_SEL) begin
				s.trig_sel = wr_byte(q.trig_sel, 8'hFF);
				cfg_wr = 1'b1;
			end else if (ADDR == ADDR_CMP_CTRL) begin
				s.cmp_ctrl = wr_byte(q.cmp_ctrl, CMP_WRITE_MASK);
				cfg_wr = 1'b1;
			end
		end

		// Register reads; unmapped addresses and wrong-size result reads give zero.
		if (RD_EN) begin
			s.rd_valid = 1'b1;
			s.rdata = 16'h0000;
			if (ADDR == ADDR_CONV_TIME) begin
				s.rdata = {8'h00, q.conv_time};
			end else if (ADDR == ADDR_CHAN_SEL) begin
				s.rdata = {8'h00, q.chan_sel};
			end else if (ADDR == ADDR_TRIG_SEL) begin
				s.rdata = {8'h00, q.trig_sel};
			end else if (ADDR == ADDR_CMP_CTRL) begin
				s.rdata = {8'h00, q.cmp_ctrl};
			end else if (SIZE16 && ADDR[31:5] == ADDR_RES_WORD[31:5] && !ADDR[0]
					&& widx < 4'(NUM_CH)) begin
				s.rdata = {q.res[widx], {RES_PAD{1'b0}}};
			end else if (!SIZE16 && ADDR[31:4] == ADDR_RES_HIGH[31:4]
					&& hidx < 4'(NUM_CH)) begin
				s.rdata = {8'h00, q.res[hidx][RES_W-1:2]};
			end
		end

		// Conversion sequencing.
		if (!CONV_EN) begin
			s.fsm = ST_IDLE;
			s.busy = 1'b0;
			t_load = 1'b1;
		end else begin
			case (q.fsm)
				ST_IDLE: begin
					if (!q.en) begin
						s.fsm = ST_STAB;
						t_load = 1'b1;
						t_count = stab_cyc;
					end
				end
				ST_STAB: begin
					if (tif.expired) begin
						if (TRIG_MODE) begin
							s.fsm = ST_WAIT_TRIG;
						end else begin
							go = 1'b1;
						end
					end
				end
				ST_WAIT_TRIG: begin
					if (trig_hit) begin
						go = 1'b1;
					end
				end
				ST_CONV: begin
					if (TRIG_MODE && trig_hit) begin
						go = 1'b1;
					end else if (cfg_wr) begin
						// A channel, trigger or compare write aborts the conversion in flight.
						if (TRIG_MODE) begin
							s.fsm = ST_WAIT_TRIG;
							s.busy = 1'b0;
							t_load = 1'b1;
						end else begin
							go = 1'b1;
						end
					end else if (tif.expired) begin
						if (q.cur_ch < 4'(NUM_CH)) begin
							if (!q.cmp_ctrl[CMP_EN_BIT]) begin
								s.res[q.cur_ch] = ANA_CODE;
								s.irq = last_ch;
							end else if (!SCAN_MODE) begin
								if (hit) begin
									s.res[q.cur_ch] = ANA_CODE;
								end
								s.irq = hit;
							end else if (q.cur_ch == 4'h0) begin
								if (hit) begin
									s.res[0] = ANA_CODE;
								end
								s.irq = hit;
							end else begin
								s.res[q.cur_ch] = ANA_CODE;
							end
						end
						if (TRIG_MODE && last_ch) begin
							s.fsm = ST_WAIT_TRIG;
							s.busy = 1'b0;
						end else begin
							go = 1'b1;
							go_ch = last_ch ? first_ch : q.cur_ch + 4'h1;
						end
					end
				end
				default: begin
					s.fsm = ST_IDLE;
				end
			endcase
		end

		// Launch one conversion on the chosen channel.
		if (go) begin
			s.fsm = ST_CONV;
			s.busy = 1'b1;
			s.cur_ch = go_ch;
			s.ana_start = 1'b1;
			t_load = 1'b1;
			t_count = conv_cyc;
		end
	end

	assign tif.load = t_load;
	assign tif.count = t_count;

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	// Results have no reset value but are cleared anyway to keep reads defined.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			q <= '0;
			q.conv_time <= REG_RESET;
			q.trig_sel <= REG_RESET;
			q.chan_sel <= REG_RESET;
			q.cmp_ctrl <= REG_RESET;
			q.fsm <= ST_IDLE;
		end else begin
			q <= s;
		end
	end

	// Outputs straight from the state register.
	assign RDATA = q.rdata;
	assign RD_VALID = q.rd_valid;
	assign ANA_START = q.ana_start;
	assign ANA_CHAN = q.cur_ch;
	assign IRQ = q.irq;
	assign BUSY = q.busy;

endmodule : adc_ctrl

/* adc_pkg.sv */
// Constants, register map and state types shared by the converter control files.
// Assumes a byte-addressed peripheral bus and a single 100 MHz peripheral clock.

package adc_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [31:0] ADDR_CONV_TIME  = 32'hFFFFF201;
	localparam logic [31:0] ADDR_CHAN_SEL   = 32'hFFFFF202;
	localparam logic [31:0] ADDR_TRIG_SEL   = 32'hFFFFF203;
	localparam logic [31:0] ADDR_CMP_CTRL   = 32'hFFFFF204;
	localparam logic [31:0] ADDR_RES_WORD   = 32'hFFFFF220;
	localparam logic [31:0] ADDR_RES_HIGH   = 32'hFFFFF240;

	// ------------------------------------------------------------------
	// Field layouts and reset values
	// ------------------------------------------------------------------
	localparam int          CT_SPEED_BIT    = 7;
	localparam logic [7:0]  CT_WRITE_MASK   = 8'h8F;
	localparam logic [7:0]  CHAN_WRITE_MASK = 8'h0F;
	localparam logic [7:0]  CMP_WRITE_MASK  = 8'hC0;
	localparam int          CMP_EN_BIT      = 7;
	localparam int          CMP_DIR_BIT     = 6;
	localparam logic [7:0]  REG_RESET       = 8'h00;
	localparam int          NUM_CH          = 12;
	localparam int          RES_W           = 10;
	localparam int          RES_PAD         = 6;

	// ------------------------------------------------------------------
	// Hardware trigger sources
	// ------------------------------------------------------------------
	localparam logic [1:0]  TRIG_EXT_PIN    = 2'h0;
	localparam logic [1:0]  TRIG_TIMER0     = 2'h1;
	localparam logic [1:0]  TRIG_TIMER1     = 2'h2;

	// ------------------------------------------------------------------
	// Timing counts in peripheral clock cycles
	// ------------------------------------------------------------------
	localparam logic [8:0]  CONV_UNIT_CYC   = 9'h01F;
	localparam logic [8:0]  STAB_CODE0_CYC  = 9'h010;
	localparam logic [8:0]  STAB_CODE1_CYC  = 9'h01F;
	localparam logic [8:0]  STAB_CODE2_CYC  = 9'h02F;
	localparam logic [8:0]  STAB_OTHER_CYC  = 9'h032;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_STAB,
		ST_WAIT_TRIG,
		ST_CONV
	} fsm_t;

endpackage : adc_pkg

/* cycle_timer_if.sv */
// Carrier between the converter sequencer and its cycle timer.
// Assumes both ends run on the same clock.

`timescale 1ns/100ps

interface cycle_timer_if;
	logic       load;
	logic [8:0] count;
	logic       expired;

	modport ctrl (output load, output count, input expired);
	modport tmr  (input load, input count, output expired);
endinterface : cycle_timer_if

/* cycle_timer.sv */
// Down counter that pulses once a loaded number of cycles has elapsed.
// Assumes the controller reloads it with zero to cancel a running count.

`timescale 1ns/100ps

module cycle_timer
	import adc_pkg::*;
(
	input  wire logic    clk,
	input  wire logic    rst_n,
	cycle_timer_if.tmr   tif
);

	typedef struct packed {
		logic [8:0] cnt;
		logic       expired;
	} tmr_state_t;

	tmr_state_t q;
	tmr_state_t d;

	// Next count; a load overrides any count in flight so a restart is clean.
	always_comb begin
		d = q;
		d.expired = 1'b0;
		if (tif.load) begin
			d.cnt = tif.count;
		end else if (q.cnt != 9'h000) begin
			d.cnt = q.cnt - 9'h001;
			d.expired = (q.cnt == 9'h001);
		end
	end

	// State register.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tif.expired = q.expired;

endmodule : cycle_timer

/* adc_ctrl_properties.sv */
// Port checks for the converter control block.
// Assumes one clock and the active-low asynchronous reset.

`timescale 1ns/100ps

module adc_ctrl_properties
	import adc_pkg::*;
(
	input wire logic        CLK,
	input wire logic        RSTN,
	input wire logic [31:0] ADDR,
	input wire logic        RD_EN,
	input wire logic        SIZE16,
	input wire logic [15:0] RDATA,
	input wire logic        RD_VALID,
	input wire logic        CONV_EN,
	input wire logic        ANA_START,
	input wire logic        IRQ,
	input wire logic        BUSY
);
	// --------------------
	// Properties
	// --------------------
	// Reset masks all checks; $past can still sample the last cycle of the reset phase.
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	property p_rd_ans; RD_EN |=> RD_VALID; endproperty
	property p_rd_cause; RD_VALID |-> $past(RD_EN); endproperty
	property p_chan_hi; RD_VALID && $past(ADDR) == ADDR_CHAN_SEL |-> RDATA[15:4] == 12'h000; endproperty
	property p_cmp_lo; RD_VALID && $past(ADDR) == ADDR_CMP_CTRL |-> RDATA[5:0] == 6'h00; endproperty
	property p_word_lo;
		RD_VALID && $past(SIZE16) && $past(ADDR[31:5]) == 27'h7FFFF91 |-> RDATA[5:0] == 6'h00;
	endproperty
	property p_stab; $rose(CONV_EN) |-> !ANA_START [*8]; endproperty
	property p_start; ANA_START |-> BUSY ##1 !ANA_START; endproperty
	property p_irq_gap; ANA_START |=> !IRQ [*8]; endproperty
	property p_idle; !CONV_EN |=> !BUSY; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("Read not answered");
	a_rd_cause: assert property (p_rd_cause) else $error("Stray read valid");
	a_chan_hi: assert property (p_chan_hi) else $error("Channel upper bits set");
	a_cmp_lo: assert property (p_cmp_lo) else $error("Compare low bits set");
	a_word_lo: assert property (p_word_lo) else $error("Result low bits set");
	a_stab: assert property (p_stab) else $error("Start inside settling wait");
	a_start: assert property (p_start) else $error("Bad start pulse");
	a_irq_gap: assert property (p_irq_gap) else $error("Conversion too short");
	a_idle: assert property (p_idle) else $error("Busy while disabled");
	c_irq: cover property (IRQ);
	c_start: cover property (ANA_START ##1 BUSY);
	c_word: cover property (RD_VALID && $past(SIZE16));
endmodule : adc_ctrl_properties

bind adc_ctrl adc_ctrl_properties chk_u (.CLK, .RSTN, .ADDR, .RD_EN, .SIZE16, .RDATA,
	.RD_VALID, .CONV_EN, .ANA_START, .IRQ, .BUSY);

/* adc_front_model.sv */
// Behavioural analog front end returning a channel-dependent code.
// Assumes the controller samples the code in the last conversion cycle.

`timescale 1ns/100ps

module adc_front_model (
	input  wire logic       clk,
	input  wire logic       ana_start,
	input  wire logic [3:0] ana_chan,
	input  wire logic       busy,
	input  wire logic [5:0] bias,
	output logic      [9:0] ana_code
);
	logic [9:0] held_q;

	// Hold captures at each start; outside a conversion the code is inverted
	// so that a late sample cannot match by chance.
	always_ff @(posedge clk) if (ana_start) held_q <= {ana_chan, bias};
	assign ana_code = busy ? held_q : ~held_q;
endmodule : adc_front_model

/* test_adc_config_result_threshold.sv */
// Self-checking bench: bus tasks and conversion scenarios.
// Assumes the package, cycle timer, controller and front-end model compile first.

`timescale 1ns/100ps

module test_adc_config_result_threshold
	import adc_pkg::*;
;
	logic        clk, rstn, wr_en, rd_en, size16, bit_op, conv_en, trig_mode, scan_mode;
	logic        ext_edge, tmr0, tmr1, ana_start, rd_valid, irq, busy;
	logic [31:0] addr;
	logic [2:0]  bit_pos;
	logic [7:0]  wdata, thr;
	logic [15:0] rdata;
	logic [9:0]  ana_code;
	logic [3:0]  ana_chan;
	logic [5:0]  bias;
	logic [3:0]  chq[$];
	int          num_errors = 0, compares = 0, starts = 0, irqs = 0, n;
	logic [31:0] ra[4] = '{ADDR_CONV_TIME, ADDR_CHAN_SEL, ADDR_TRIG_SEL, ADDR_CMP_CTRL};
	logic [7:0]  wv[4] = '{8'h8F, 8'hFB, 8'h02, 8'hFF};
	logic [7:0]  rv[4] = '{8'h8F, 8'h0B, 8'h02, 8'hC0};

	adc_ctrl dut_u (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en),
		.SIZE16(size16), .BIT_OP(bit_op), .BIT_POS(bit_pos), .WDATA(wdata), .RDATA(rdata),
		.RD_VALID(rd_valid), .CONV_EN(conv_en), .TRIG_MODE(trig_mode),
		.SCAN_MODE(scan_mode), .THRESHOLD(thr), .EXT_EDGE(ext_edge), .TMR_MATCH0(tmr0),
		.TMR_MATCH1(tmr1), .ANA_CODE(ana_code), .ANA_START(ana_start), .ANA_CHAN(ana_chan),
		.IRQ(irq), .BUSY(busy));
	adc_front_model fe_u (.clk(clk), .ana_start(ana_start), .ana_chan(ana_chan),
		.busy(busy), .bias(bias), .ana_code(ana_code));

	// Free-running 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Count starts and interrupts, and log the channel of each start.
	always @(posedge clk) begin
		if (ana_start === 1'b1) begin
			starts++;
			chq.push_back(ana_chan);
		end
		if (irq === 1'b1) irqs++;
	end

	// --------------------
	// Tasks
	// --------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Bus writes are one-cycle strobes; the value lands at the next edge.
	task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic b = 1'b0,
		input logic [2:0] p = 3'h0);
		addr = a;
		wdata = d;
		bit_op = b;
		bit_pos = p;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
		// An idle cycle follows, so a second call never lifts the strobe in the same step.
		@(negedge clk);
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic s, input logic [15:0] exp);
		addr = a;
		size16 = s;
		rd_en = 1'b1;
		@(negedge clk);
		rd_en = 1'b0;
		chk({15'h0000, rd_valid}, 16'h0001);
		chk(rdata, exp);
		@(negedge clk);
	endtask : rd

	// Counts settled cycles until a start (0) or an interrupt (1), bounded.
	task automatic wait_on(input bit which, output int cnt);
		cnt = 0;
		do begin
			@(negedge clk);
			cnt++;
		end while ((which ? irq : ana_start) !== 1'b1 && cnt < 2000);
		if (cnt >= 2000) begin
			num_errors++;
			finish_test();
		end
	endtask : wait_on

	task automatic run_sel(input logic [3:0] code, input int stab);
		wr(ADDR_CONV_TIME, {4'h8, code});
		conv_en = 1'b1;
		wait_on(1'b0, n);
		chk(16'(n), 16'(stab + 2));
		wait_on(1'b1, n);
		chk(16'(n), 16'(31 * (code + 1)));
		conv_en = 1'b0;
	endtask : run_sel

	// Pulses the selected trigger inputs for one cycle, then lets them settle.
	task automatic fire(input logic [2:0] m);
		{tmr1, tmr0, ext_edge} = m;
		@(negedge clk);
		{tmr1, tmr0, ext_edge} = 3'h0;
		repeat (3) @(negedge clk);
	endtask : fire

	task automatic finish_test();
		$display("Compares %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test

	// --------------------
	// Scenarios
	// --------------------
	initial begin
		{rstn, wr_en, rd_en, size16, bit_op, conv_en, trig_mode, scan_mode} = '0;
		{ext_edge, tmr0, tmr1} = '0;
		addr = '0;
		bit_pos = '0;
		wdata = '0;
		thr = 8'h18;
		bias = 6'h2A;
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		foreach (ra[i]) begin
			rd(ra[i], 1'b0, 16'h0000);
			wr(ra[i], wv[i]);
			rd(ra[i], 1'b0, {8'h00, rv[i]});
		end
		wr(ADDR_CMP_CTRL, 8'h00, 1'b1, 3'h7);
		wr(ADDR_CMP_CTRL, 8'h01, 1'b1, 3'h2);
		rd(ADDR_CMP_CTRL, 1'b0, 16'h0040);
		wr(ADDR_CMP_CTRL, 8'h00);
		wr(ADDR_RES_WORD, 8'hFF);
		rd(ADDR_RES_WORD, 1'b1, 16'h0000);
		rd(32'hFFFFF2F0, 1'b0, 16'h0000);
		$display("Register test done");
		// Short codes break the clock-rate limit on purpose to reach every settling count.
		wr(ADDR_CHAN_SEL, 8'h01);
		run_sel(4'h0, 16);
		run_sel(4'h1, 31);
		run_sel(4'h2, 47);
		run_sel(4'h9, 50);
		rd(ADDR_RES_WORD + 32'h2, 1'b1, {4'h1, bias, 6'h00});
		rd(ADDR_RES_HIGH + 32'h1, 1'b0, {8'h00, 4'h1, bias[5:2]});
		rd(ADDR_RES_WORD + 32'h2, 1'b0, 16'h0000);
		$display("Timing test done");
		wr(ADDR_CONV_TIME, 8'h80);
		bias = 6'h00;
		for (int d = 0; d < 2; d++) begin
			wr(ADDR_CMP_CTRL, {1'b1, d[0], 6'h00});
			irqs = 0;
			conv_en = 1'b1;
			repeat (100) @(negedge clk);
			conv_en = 1'b0;
			chk(16'(irqs != 0), 16'(d));
			rd(ADDR_RES_WORD + 32'h2, 1'b1, d ? 16'h1000 : 16'h1A80);
		end
		$display("Select compare test done");
		wr(ADDR_CMP_CTRL, 8'h00);
		wr(ADDR_CHAN_SEL, 8'h02);
		scan_mode = 1'b1;
		bias = 6'h2A;
		chq.delete();
		irqs = 0;
		conv_en = 1'b1;
		repeat (150) @(negedge clk);
		conv_en = 1'b0;
		chk(16'({chq[0], chq[1], chq[2], chq[3]}), 16'h0120);
		chk(16'(irqs), 16'h0001);
		wr(ADDR_CMP_CTRL, 8'h80);
		bias = 6'h00;
		irqs = 0;
		conv_en = 1'b1;
		repeat (150) @(negedge clk);
		conv_en = 1'b0;
		chk(16'(irqs), 16'h0000);
		rd(ADDR_RES_HIGH + 32'h2, 1'b0, 16'h0020);
		rd(ADDR_RES_HIGH, 1'b0, 16'h000A);
		$display("Scan test done");
		wr(ADDR_CMP_CTRL, 8'h00);
		wr(ADDR_CHAN_SEL, 8'h01);
		scan_mode = 1'b0;
		trig_mode = 1'b1;
		for (int s = 0; s < 3; s++) begin
			wr(ADDR_TRIG_SEL, 8'(s));
			conv_en = 1'b1;
			repeat (30) @(negedge clk);
			starts = 0;
			fire(3'h7 & ~(3'h1 << s));
			chk(16'(starts), 16'h0000);
			fire(3'h1 << s);
			chk(16'(starts), 16'h0001);
			chk({15'h0000, busy}, 16'h0001);
			fire(3'h1 << s);
			chk(16'(starts), 16'h0002);
			conv_en = 1'b0;
			@(negedge clk);
		end
		$display("Trigger test done");
		finish_test();
	end
endmodule : test_adc_config_result_threshold
